// >>> include/uim_regs.svh
/*
 Register offsets, field positions and reset values of the interrupt mask block.
 Assumes inclusion by bare name from the package and the core.
*/
`ifndef UIM_REGS_SVH
`define UIM_REGS_SVH

`define UIM_ADDR_MODE        8'h0C
`define UIM_ADDR_IRQ_CFG     8'h10
`define UIM_ADDR_MASK        8'h14
`define UIM_ADDR_PENDING     8'h18

`define UIM_MASK_RESET       32'h0000_0000
`define UIM_MASK_BUS_RESET   32'h0000_0001
`define UIM_MASK_WRITABLE    32'h03FF_FDFF
`define UIM_ZERO             32'h0000_0000

`define UIM_MODE_GATE_BIT    0
`define UIM_CFG_CTRL_LSB     0
`define UIM_CFG_DIN_LSB      2
`define UIM_CFG_DOUT_LSB     4
`define UIM_CFG_WIDTH        6

`define UIM_BIT_BUS_RESET    5'h00
`define UIM_BIT_FRAME        5'h01
`define UIM_BIT_PSEUDO_FRAME 5'h02
`define UIM_BIT_SUSPEND      5'h03
`define UIM_BIT_RESUME       5'h04
`define UIM_BIT_SPEED        5'h05
`define UIM_BIT_DMA          5'h06
`define UIM_BIT_SUPPLY       5'h07
`define UIM_BIT_SETUP        5'h08
`define UIM_BIT_EP_BASE      5'h0A
`define UIM_BIT_CTRL_OUT     5'h0A
`define UIM_BIT_CTRL_IN      5'h0B
`define UIM_BUS_EVT_WIDTH    8
`define UIM_EP_CTRL          3'h0
`define UIM_FIRST_DATA_EP    1
`define UIM_LAST_EP          7

`endif

// >>> include/uim_pkg.sv
/*
 Types shared by the interrupt mask block.
 Assumes uim_regs.svh is on the include path.
*/
`include "uim_regs.svh"

package uim_pkg;

   // Handshake report from the serial engine, at most one per cycle
   typedef struct packed {
      logic       valid;
      logic       nak;
      logic       setup;
      logic       dir_in;
      logic [2:0] ep;
   } uim_hs_evt_t;

   typedef enum logic [1:0] {
      UIM_POL_ACK_NAK   = 2'h0,
      UIM_POL_ACK       = 2'h1,
      UIM_POL_FIRST_NAK = 2'h2,
      UIM_POL_RSVD      = 2'h3
   } uim_policy_t;

endpackage : uim_pkg

// >>> core/uim_top.sv
/*
 Interrupt enable mask of a high-speed USB peripheral controller, with an
 APB slave for the mode, interrupt configuration, mask and pending registers.
 Assumes the serial engine reports handshakes and bus events as one-cycle
 pulses synchronous to pclk, and a bus reset as a one-cycle pulse.
*/
// Local design decision: the APB register port.
// Overview of operation
// [RULE_01] Mask is one 32-bit read/write register, four bytes, at address 0x14.
// [RULE_02] Bits 25..12 pair transmit/receive enables for endpoints 7 down to 1.
// [RULE_03] Bit 11 enables control IN, bit 10 control OUT of endpoint 0.
// [RULE_04] Bit 8 enables setup arrival; bits 9 and 31..26 reserved.
// [RULE_05] Cleared global gate in mode register suppresses every interrupt.
// [RULE_06] Endpoint events come from ACK or NAK handshakes, filtered by policy.
// [RULE_07] Data IN uses IN policy field, data OUT uses OUT policy field.
// [RULE_08] All endpoint 0 control transactions use the control policy field.
// [RULE_09] USB bus reset clears the mask except bit 0, which becomes one.
// [RULE_10] Bit 7 enables the supply sensing interrupt.
// [RULE_11] Bit 6 enables the DMA reason change interrupt.
// [RULE_12] Bit 5 enables the high-speed status change interrupt.
// [RULE_13] Bit 4 enables resume, bit 3 enables suspend interrupts.
// [RULE_14] Bit 2 enables pseudo frame start, bit 1 frame start interrupts.
// [RULE_15] Bit 0 enables the bus reset interrupt.
// [RULE_16] Mask reads zero after reset; irq needs pending, enabled and gate.
`include "uim_regs.svh"

module uim_top (
   input  wire  logic                     pclk,
   input  wire  logic                     presetn,
   input  wire  logic                     psel,
   input  wire  logic                     penable,
   input  wire  logic                     pwrite,
   input  wire  logic [7:0]               paddr,
   input  wire  logic [31:0]              pwdata,
   output       logic [31:0]              prdata,
   output       logic                     pready,
   output       logic                     pslverr,
   input  wire  uim_pkg::uim_hs_evt_t     hs_evt,
   input  wire  logic [7:0]               bus_evt,
   input  wire  logic                     usb_bus_reset,
   output       logic [31:0]              irq_mask,
   output       logic                     irq
);
   import uim_pkg::*;

   logic [31:0]                interrupt_source_mask;
   logic [31:0]                next_interrupt_source_mask;
   logic [31:0]                pending;
   logic [31:0]                next_pending;
   logic [31:0]                nak_seen;
   logic [31:0]                next_nak_seen;
   logic                       global_irq_gate;
   logic                       next_global_irq_gate;
   logic [`UIM_CFG_WIDTH-1:0]  irq_cfg;
   logic [`UIM_CFG_WIDTH-1:0]  next_irq_cfg;
   logic [31:0]                next_prdata;
   logic                       next_pready;
   logic                       next_pslverr;
   logic                       next_irq;

   logic                       wr_go;
   logic                       wr_mode;
   logic                       wr_cfg;
   logic                       wr_mask;
   logic                       wr_pend;
   logic                       rd_cycle;
   logic                       mapped;
   logic [4:0]                 hs_bit;
   logic [1:0]                 hs_policy;
   logic                       hs_take;
   logic [31:0]                hs_set;
   logic [31:0]                evt_set;
   logic [31:0]                enabled_src;

   // Mask fields under their own names
   logic                       bus_reset_irq_en;
   logic                       frame_start_irq_en;
   logic                       pseudo_frame_irq_en;
   logic                       suspend_irq_en;
   logic                       resume_irq_en;
   logic                       speed_change_irq_en;
   logic                       dma_reason_irq_en;
   logic                       supply_sense_irq_en;
   logic                       setup_rx_irq_en;
   logic                       ctrl_out_irq_en;
   logic                       ctrl_in_irq_en;
   logic [`UIM_LAST_EP:`UIM_FIRST_DATA_EP] ep_tx_irq_en;
   logic [`UIM_LAST_EP:`UIM_FIRST_DATA_EP] ep_rx_irq_en;

   uim_policy_t                control_ep_irq_policy;
   uim_policy_t                data_in_irq_policy;
   uim_policy_t                data_out_irq_policy;

   // Pending bit that a handshake on this endpoint and direction lands on
   function automatic logic [4:0] uim_src_bit(input logic       setup,
                                              input logic [2:0] ep,
                                              input logic       dir_in);
      if (setup) begin
         uim_src_bit = `UIM_BIT_SETUP;
      end else begin
         uim_src_bit = `UIM_BIT_EP_BASE + {1'b0, ep, dir_in};
      end
   endfunction : uim_src_bit

   // Whether a handshake raises an event under the given policy
   function automatic logic uim_policy_take(input logic [1:0] pol,
                                            input logic       nak,
                                            input logic       seen);
      case (pol)
         UIM_POL_ACK_NAK:   uim_policy_take = 1'b1;
         UIM_POL_ACK:       uim_policy_take = ~nak;
         UIM_POL_FIRST_NAK: uim_policy_take = ~nak | ~seen;
         default:           uim_policy_take = ~nak;
      endcase
   endfunction : uim_policy_take

   function automatic logic uim_is_mapped(input logic [7:0] addr);
      uim_is_mapped = (addr == `UIM_ADDR_MODE) || (addr == `UIM_ADDR_IRQ_CFG)
                    || (addr == `UIM_ADDR_MASK) || (addr == `UIM_ADDR_PENDING);
   endfunction : uim_is_mapped

   // Write strobe for one register
   function automatic logic uim_wr_hit(input logic       go,
                                       input logic [7:0] addr,
                                       input logic [7:0] target);
      uim_wr_hit = go && (addr == target);
   endfunction : uim_wr_hit

   assign control_ep_irq_policy =
      uim_policy_t'(irq_cfg[`UIM_CFG_CTRL_LSB +: 2]);
   assign data_in_irq_policy    =
      uim_policy_t'(irq_cfg[`UIM_CFG_DIN_LSB +: 2]);
   assign data_out_irq_policy   =
      uim_policy_t'(irq_cfg[`UIM_CFG_DOUT_LSB +: 2]);

   // Handshake classification
   always_comb begin
      hs_bit = uim_src_bit(hs_evt.setup, hs_evt.ep, hs_evt.dir_in); // [RULE_03] [RULE_04]
      if (hs_evt.setup || (hs_evt.ep == `UIM_EP_CTRL)) begin
         hs_policy = control_ep_irq_policy;                                // [RULE_08]
      end else if (hs_evt.dir_in) begin
         hs_policy = data_in_irq_policy;                                   // [RULE_07]
      end else begin
         hs_policy = data_out_irq_policy;                                  // [RULE_07]
      end
      hs_take = hs_evt.valid
              && uim_policy_take(hs_policy, hs_evt.nak, nak_seen[hs_bit]); // [RULE_06]
      hs_set  = `UIM_ZERO;
      if (hs_take) begin
         hs_set[hs_bit] = 1'b1;                                            // [RULE_06]
      end
      // Bus events land on bits 7..0 in mask order
      evt_set = {{(32-`UIM_BUS_EVT_WIDTH){1'b0}}, bus_evt};            // [RULE_10] [RULE_11]
   end

   // APB decode: answer comes one cycle into the access phase
   always_comb begin
      rd_cycle     = psel && penable && !pready;
      wr_go        = psel && penable && pready && pwrite;
      wr_mode      = uim_wr_hit(wr_go, paddr, `UIM_ADDR_MODE);
      wr_cfg       = uim_wr_hit(wr_go, paddr, `UIM_ADDR_IRQ_CFG);
      wr_mask      = uim_wr_hit(wr_go, paddr, `UIM_ADDR_MASK);             // [RULE_01]
      wr_pend      = uim_wr_hit(wr_go, paddr, `UIM_ADDR_PENDING);
      mapped       = uim_is_mapped(paddr);
      next_pready  = rd_cycle;
      next_pslverr = rd_cycle && !mapped;
      next_prdata  = `UIM_ZERO;
      if (rd_cycle && !pwrite) begin
         case (paddr)
            `UIM_ADDR_MODE: begin
               next_prdata[`UIM_MODE_GATE_BIT] = global_irq_gate;
            end
            `UIM_ADDR_IRQ_CFG: begin
               next_prdata[`UIM_CFG_WIDTH-1:0] = irq_cfg;
            end
            `UIM_ADDR_MASK: begin
               next_prdata = interrupt_source_mask;                        // [RULE_01]
            end
            `UIM_ADDR_PENDING: begin
               next_prdata = pending;
            end
            default: begin
               next_prdata = `UIM_ZERO;
            end
         endcase
      end
   end

   // Named enable fields; reserved bits never reach them
   always_comb begin
      bus_reset_irq_en    = interrupt_source_mask[`UIM_BIT_BUS_RESET];     // [RULE_15]
      frame_start_irq_en  = interrupt_source_mask[`UIM_BIT_FRAME];         // [RULE_14]
      pseudo_frame_irq_en = interrupt_source_mask[`UIM_BIT_PSEUDO_FRAME];  // [RULE_14]
      suspend_irq_en      = interrupt_source_mask[`UIM_BIT_SUSPEND];       // [RULE_13]
      resume_irq_en       = interrupt_source_mask[`UIM_BIT_RESUME];        // [RULE_13]
      speed_change_irq_en = interrupt_source_mask[`UIM_BIT_SPEED];         // [RULE_12]
      dma_reason_irq_en   = interrupt_source_mask[`UIM_BIT_DMA];           // [RULE_11]
      supply_sense_irq_en = interrupt_source_mask[`UIM_BIT_SUPPLY];        // [RULE_10]
      setup_rx_irq_en     = interrupt_source_mask[`UIM_BIT_SETUP];         // [RULE_04]
      ctrl_out_irq_en     = interrupt_source_mask[`UIM_BIT_CTRL_OUT];      // [RULE_03]
      ctrl_in_irq_en      = interrupt_source_mask[`UIM_BIT_CTRL_IN];       // [RULE_03]
      ep_tx_irq_en        = '0;
      ep_rx_irq_en        = '0;
      for (int n = `UIM_FIRST_DATA_EP; n <= `UIM_LAST_EP; n++) begin
         ep_tx_irq_en[n] = interrupt_source_mask[uim_src_bit(1'b0, 3'(n), 1'b1)]; // [RULE_02]
         ep_rx_irq_en[n] = interrupt_source_mask[uim_src_bit(1'b0, 3'(n), 1'b0)]; // [RULE_02]
      end
   end

   // Enables put back in source order for the irq term
   always_comb begin
      enabled_src                        = `UIM_ZERO;
      enabled_src[`UIM_BIT_BUS_RESET]    = bus_reset_irq_en;
      enabled_src[`UIM_BIT_FRAME]        = frame_start_irq_en;
      enabled_src[`UIM_BIT_PSEUDO_FRAME] = pseudo_frame_irq_en;
      enabled_src[`UIM_BIT_SUSPEND]      = suspend_irq_en;
      enabled_src[`UIM_BIT_RESUME]       = resume_irq_en;
      enabled_src[`UIM_BIT_SPEED]        = speed_change_irq_en;
      enabled_src[`UIM_BIT_DMA]          = dma_reason_irq_en;
      enabled_src[`UIM_BIT_SUPPLY]       = supply_sense_irq_en;
      enabled_src[`UIM_BIT_SETUP]        = setup_rx_irq_en;
      enabled_src[`UIM_BIT_CTRL_OUT]     = ctrl_out_irq_en;
      enabled_src[`UIM_BIT_CTRL_IN]      = ctrl_in_irq_en;
      for (int n = `UIM_FIRST_DATA_EP; n <= `UIM_LAST_EP; n++) begin
         enabled_src[uim_src_bit(1'b0, 3'(n), 1'b1)] = ep_tx_irq_en[n];
         enabled_src[uim_src_bit(1'b0, 3'(n), 1'b0)] = ep_rx_irq_en[n];
      end
   end

   // Global gate in the mode register
   always_comb begin
      next_global_irq_gate = global_irq_gate;
      if (wr_mode) begin
         next_global_irq_gate = pwdata[`UIM_MODE_GATE_BIT];                // [RULE_05]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_irq_gate <= 1'b0;
      end else begin
         global_irq_gate <= next_global_irq_gate;
      end
   end

   // Policy fields of the interrupt configuration register
   always_comb begin
      next_irq_cfg = irq_cfg;
      if (wr_cfg) begin
         next_irq_cfg = pwdata[`UIM_CFG_WIDTH-1:0];                        // [RULE_07] [RULE_08]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_cfg <= '0;
      end else begin
         irq_cfg <= next_irq_cfg;
      end
   end

   // Enable mask; a bus reset wins over a write in the same cycle
   always_comb begin
      next_interrupt_source_mask = interrupt_source_mask;
      if (wr_mask) begin
         next_interrupt_source_mask = pwdata & `UIM_MASK_WRITABLE;        // [RULE_01] [RULE_04]
      end
      if (usb_bus_reset) begin
         next_interrupt_source_mask = `UIM_MASK_BUS_RESET;                 // [RULE_09]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_source_mask <= `UIM_MASK_RESET;                         // [RULE_16]
         irq_mask              <= `UIM_MASK_RESET;
      end else begin
         interrupt_source_mask <= next_interrupt_source_mask;
         irq_mask              <= next_interrupt_source_mask;
      end
   end

   // Sticky pending bits, set after clear so a fresh event is never lost
   always_comb begin
      next_pending = pending;
      if (wr_pend) begin
         next_pending = pending & ~pwdata;
      end
      next_pending = (next_pending | hs_set | evt_set) & `UIM_MASK_WRITABLE;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending <= `UIM_ZERO;
      end else begin
         pending <= next_pending;
      end
   end

   // Last handshake per source was a NAK; a bus reset forgets it
   always_comb begin
      next_nak_seen = nak_seen;
      if (hs_evt.valid) begin
         next_nak_seen[hs_bit] = hs_evt.nak;                               // [RULE_06]
      end
      if (usb_bus_reset) begin
         next_nak_seen = `UIM_ZERO;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nak_seen <= `UIM_ZERO;
      end else begin
         nak_seen <= next_nak_seen;
      end
   end

   // APB answer, one cycle wide
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= `UIM_ZERO;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Request needs a pending source, its enable and the global gate
   always_comb begin
      next_irq = global_irq_gate                                           // [RULE_05]
               && |(pending & enabled_src);                                // [RULE_16]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

endmodule : uim_top

// >>> tb/uim_properties.sv
/*
 Checker for the mask register and its APB answers.
 Assumes binding to uim_top, one clock domain.
*/
module uim_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        usb_bus_reset,
   input wire logic [31:0] irq_mask,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic wr_mask;
   assign acc = psel && penable && pready;
   assign wr_mask = acc && pwrite && paddr == 8'h14;
   property p_wait;
      psel && penable && !pready && $past(psel && !penable) |=> pready;
   endproperty
   property p_wr;
      wr_mask && !usb_bus_reset |=> irq_mask == ($past(pwdata) & 32'h03FF_FDFF);
   endproperty
   property p_rd;
      acc && !pwrite && paddr == 8'h14 |-> prdata == irq_mask && !pslverr;
   endproperty
   property p_err;
      pslverr |-> pready && prdata == 32'h0000_0000;
   endproperty
   property p_rsvd;
      irq_mask[31:26] == 6'h00 && !irq_mask[9];
   endproperty
   property p_brst;
      usb_bus_reset |=> irq_mask == 32'h0000_0001;
   endproperty
   property p_hold;
      !wr_mask && !usb_bus_reset |=> $stable(irq_mask);
   endproperty
   property p_off;
      irq_mask == 32'h0000_0000 |=> !irq;
   endproperty
   a_wait: assert property (p_wait) else $error("late pready");
   a_wr: assert property (p_wr) else $error("mask write lost");
   a_rd: assert property (p_rd) else $error("mask read wrong");
   a_err: assert property (p_err) else $error("bad error answer");
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   a_brst: assert property (p_brst) else $error("bus reset mask");
   a_hold: assert property (p_hold) else $error("mask changed");
   a_off: assert property (p_off) else $error("irq while masked");
   c_brst: cover property (usb_bus_reset);
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
endmodule : uim_properties

bind uim_top uim_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .usb_bus_reset, .irq_mask, .irq);

// >>> tb/uim_sie_model.sv
/*
 Serial engine stand-in issuing handshakes and bus events.
 Assumes its tasks are called from the bench.
*/
module uim_sie_model (
   input  wire logic                 pclk,
   output      uim_pkg::uim_hs_evt_t hs_evt,
   output      logic [7:0]           bus_evt,
   output      logic                 usb_bus_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   import uim_pkg::*;
   initial begin
      hs_evt = '0;
      bus_evt = '0;
      usb_bus_reset = 1'b0;
   end
   task automatic hs(input logic n, input logic s, input logic d, input logic [2:0] e);
      @(posedge pclk);
      hs_evt <= '{1'b1, n, s, d, e};
      @(posedge pclk);
      hs_evt <= '0;
   endtask : hs
   task automatic bus(input logic [7:0] b);
      @(posedge pclk);
      bus_evt <= b;
      @(posedge pclk);
      bus_evt <= '0;
   endtask : bus
   task automatic rst();
      @(posedge pclk);
      usb_bus_reset <= 1'b1;
      @(posedge pclk);
      usb_bus_reset <= 1'b0;
   endtask : rst
endmodule : uim_sie_model

// >>> tb/usb_interrupt_enable_mask_bench.sv
/*
 Self-checking bench for uim_top.
 Assumes uim_sie_model and the checker are compiled alongside.
*/
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module usb_interrupt_enable_mask_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic                 usb_bus_reset, err;
   logic [7:0]           paddr, bus_evt;
   logic [31:0]          pwdata, prdata, irq_mask, rd;
   uim_pkg::uim_hs_evt_t hs_evt;
   int                   bad_count = 0;
   int                   num_checks = 0;
   uim_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .hs_evt, .bus_evt, .usb_bus_reset, .irq_mask, .irq);
   uim_sie_model sie (.pclk, .hs_evt, .bus_evt, .usb_bus_reset);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic test_done();
      if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
   endtask : tick
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic fire(input int b);
      if (b < 8) sie.bus(8'(1 << b));
      else if (b == 8) sie.hs(1'b0, 1'b1, 1'b0, 3'd0);
      else sie.hs(1'b0, 1'b0, 1'(b % 2), 3'((b - 10) / 2));
   endtask : fire
   task automatic t_regs();
      apb(1'b0, 8'h14, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      apb(1'b1, 8'h14, 32'hFFFF_FFFF);
      apb(1'b0, 8'h14, 32'h0000_0000);
      `CHK(rd, 32'h03FF_FDFF)
      `CHK(irq_mask, 32'h03FF_FDFF)
      apb(1'b0, 8'h40, 32'h0000_0000);
      `CHK({err, rd}, {1'b1, 32'h0000_0000})
   endtask : t_regs
   task automatic t_src();
      apb(1'b1, 8'h0C, 32'h0000_0001);
      for (int b = 0; b < 26; b++) begin
         if (b == 9) continue;
         apb(1'b1, 8'h18, 32'hFFFF_FFFF);
         apb(1'b1, 8'h14, ~(32'h1 << b));
         fire(b);
         tick(2);
         `CHK(irq, 1'b0)
         apb(1'b1, 8'h14, 32'h1 << b);
         tick(2);
         `CHK(irq, 1'b1)
      end
   endtask : t_src
   task automatic t_gate();
      apb(1'b1, 8'h0C, 32'h0000_0000);
      tick(2);
      `CHK(irq, 1'b0)
   endtask : t_gate
   task automatic t_pol();
      apb(1'b1, 8'h0C, 32'h0000_0001);
      apb(1'b1, 8'h18, 32'hFFFF_FFFF);
      apb(1'b1, 8'h10, 32'h0000_0001);
      sie.hs(1'b1, 1'b0, 1'b1, 3'd0);
      sie.hs(1'b1, 1'b0, 1'b1, 3'd1);
      apb(1'b0, 8'h18, 32'h0000_0000);
      `CHK(rd, 32'h0000_2000)
      apb(1'b1, 8'h18, 32'hFFFF_FFFF);
      apb(1'b1, 8'h10, 32'h0000_0010);
      sie.hs(1'b1, 1'b0, 1'b0, 3'd2);
      sie.hs(1'b1, 1'b0, 1'b1, 3'd2);
      apb(1'b0, 8'h18, 32'h0000_0000);
      `CHK(rd, 32'h0000_8000)
      apb(1'b1, 8'h18, 32'hFFFF_FFFF);
      apb(1'b1, 8'h10, 32'h0000_0002);
      sie.hs(1'b1, 1'b0, 1'b0, 3'd0);
      apb(1'b0, 8'h18, 32'h0000_0000);
      `CHK(rd, 32'h0000_0400)
      apb(1'b1, 8'h18, 32'hFFFF_FFFF);
      sie.hs(1'b1, 1'b0, 1'b0, 3'd0);
      apb(1'b1, 8'h10, 32'h0000_0003);
      sie.hs(1'b1, 1'b1, 1'b0, 3'd0);
      apb(1'b0, 8'h18, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
   endtask : t_pol
   task automatic t_brst();
      apb(1'b1, 8'h14, 32'hFFFF_FFFF);
      sie.rst();
      apb(1'b0, 8'h14, 32'h0000_0000);
      `CHK(rd, 32'h0000_0001)
      @(posedge pclk);
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      apb(1'b0, 8'h14, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
   endtask : t_brst
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_src();
      t_gate();
      t_pol();
      t_brst();
      test_done();
   end
endmodule : usb_interrupt_enable_mask_bench
